/* File: logic/blc_backlight_ctrl.sv */
// Top of the backlight brightness control: serial registers, source select, ramp, mapping.
`timescale 1ns/10ps
// Summary of operation
// - Enable pin low: shutdown, defaults, bus ignored.
// - Enable pin high: device on, writes accepted.
// - Three string enable bits, all on.
// - Defaults: chip on, sampled input on, linear.
// - Defaults alone: standby until nonzero duty seen.
// - Standby keeps every programmed register.
// - Mode picks serial code, duty, or product.
// - Zero selected source keeps standby, zero current.
// - Config bit seven selects exponential mapping.
// - Linear: offset plus step times code.
// - Exponential: base times 1.00304 per code.
// - Mapping uses the ramped code.
// - Duty cycle measured into 11-bit code.
// - Selectable sample rates trade resolution, power.
// - Input low for timeout: duty reads zero; boost off in duty and product modes.
// - Hysteresis only after a direction change.
// - Filter rejects short input glitches.
module blc_backlight_ctrl
  import blc_pkg::*;
#(
  parameter logic [6:0]  DEV_ADDR     = 7'h40,
  parameter int unsigned TMO_SLOW_CYC = TMO_SLOW_US * CLK_MHZ,
  parameter int unsigned TMO_MID_CYC  = TMO_MID_US * CLK_MHZ,
  parameter int unsigned TMO_FAST_CYC = TMO_FAST_US * CLK_MHZ
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              sample_clk_in,
  input  wire logic              master_enable_pin_in,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  input  wire logic              pwm_in,
  output logic                   sda_out,
  output logic                   sda_oe_out,
  output logic      [CUR_W-1:0]  led_current_na_out,
  output logic      [CODE_W-1:0] led_brightness_code_out,
  output logic      [2:0]        string_en_out,
  output logic                   boost_en_out,
  output logic      [1:0]        dev_state_out
);
  logic                hw_s1_q, hw_s2_q, rst_req_q, dev_rst;
  logic                scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
  logic                pwm_s1_q, pwm_s2_q, tog_s1_q, tog_s2_q, tog_s3_q, duty_toggle;
  logic                scl_rise, scl_fall, bus_start, bus_stop, duty_new;
  logic [7:0]          en_q, cfg_q, pwmc_q, code_hi_q;
  logic [2:0]          code_lo_q;
  blc_i2c_t            ist_q, nxt_q;
  logic [7:0]          shift_q, ptr_q, wa_q, wd_q, rd_byte;
  logic [3:0]          bit_q;
  logic                wr_q, nack_q;
  logic [CODE_W-1:0]   duty_raw, pwm_code_q, hyst_thr, pwm_eff, i2c_code, sel, target_q;
  logic                dir_up_q, alive_q;
  logic [TMO_W-1:0]    tmo_q;
  logic [2*CODE_W-1:0] product;
  blc_state_t          state_q;
  logic [7:0]          rcnt_q;
  logic [CODE_W-1:0]   code_q;
  logic [CUR_W-1:0]    exp_q;

  function automatic logic [7:0] rd_reg(input logic [7:0] a);
    case (a)
      REG_ENABLE:  rd_reg = en_q;
      REG_CONFIG:  rd_reg = cfg_q;
      REG_PWM:     rd_reg = pwmc_q;
      REG_CODE_LO: rd_reg = {5'h00, code_lo_q};
      REG_CODE_HI: rd_reg = code_hi_q;
      default:     rd_reg = 8'h00;
    endcase
  endfunction

  function automatic logic [TMO_W-1:0] tmo_lim(input logic [1:0] r);
    case (r)
      2'b00:   tmo_lim = TMO_W'(TMO_SLOW_CYC);
      2'b01:   tmo_lim = TMO_W'(TMO_MID_CYC);
      default: tmo_lim = TMO_W'(TMO_FAST_CYC);
    endcase
  endfunction

  // The enable pin is synchronised and then acts as the device reset.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hw_s1_q   <= 1'b0;
      hw_s2_q   <= 1'b0;
      rst_req_q <= 1'b1;
    end else begin
      hw_s1_q   <= master_enable_pin_in;
      hw_s2_q   <= hw_s1_q;
      rst_req_q <= ~hw_s2_q;
    end
  end
  assign dev_rst = rst_in | ~hw_s2_q;

  // Pin synchronisers; the third stage exists only for edge detection.
  always_ff @(posedge clk_in) begin
    scl_s1_q <= scl_in;
    scl_s2_q <= scl_s1_q;
    scl_s3_q <= scl_s2_q;
    sda_s1_q <= sda_in;
    sda_s2_q <= sda_s1_q;
    sda_s3_q <= sda_s2_q;
    pwm_s1_q <= pwm_in;
    pwm_s2_q <= pwm_s1_q;
    tog_s1_q <= duty_toggle;
    tog_s2_q <= tog_s1_q;
    tog_s3_q <= tog_s2_q;
  end
  assign scl_rise  = scl_s2_q & ~scl_s3_q;
  assign scl_fall  = ~scl_s2_q & scl_s3_q;
  assign bus_start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  assign bus_stop  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
  assign duty_new  = tog_s2_q ^ tog_s3_q;
  assign rd_byte   = rd_reg(ptr_q); // Byte that the next read cycle returns.

  // Sampling side runs on its own clock and hands codes over by toggle.
  blc_pwm_sampler u_sampler (
    .sample_clk_in   (sample_clk_in),
    .rst_req_in      (rst_req_q),
    .pwm_in          (pwm_in),
    .rate_in         (pwmc_q[PWM_RATE_LSB +: 2]),
    .filt_in         (pwmc_q[PWM_FILT_LSB +: 2]),
    .duty_code_out   (duty_raw),
    .duty_toggle_out (duty_toggle)
  );

  // Serial slave; held idle while the device is shut down, so the bus is ignored.
  always_ff @(posedge clk_in) begin
    wr_q <= 1'b0;
    if (dev_rst) begin
      ist_q      <= BLC_I_IDLE;
      nxt_q      <= BLC_I_IDLE;
      shift_q    <= 8'h00;
      ptr_q      <= 8'h00;
      bit_q      <= 4'h0;
      nack_q     <= 1'b0;
      wa_q       <= 8'h00;
      wd_q       <= 8'h00;
      sda_oe_out <= 1'b0;
    end else if (bus_start) begin
      ist_q      <= BLC_I_ADDR;
      bit_q      <= 4'h0;
      sda_oe_out <= 1'b0;
    end else if (bus_stop) begin
      ist_q      <= BLC_I_IDLE;
      sda_oe_out <= 1'b0;
    end else begin
      case (ist_q)
        BLC_I_ADDR, BLC_I_REG, BLC_I_DATA: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_s2_q};
            bit_q   <= bit_q + 4'h1;
          end else if (scl_fall && bit_q == I2C_BITS) begin
            ist_q      <= BLC_I_ACK;
            sda_oe_out <= 1'b1;
            if (ist_q == BLC_I_ADDR) begin
              nxt_q <= shift_q[0] ? BLC_I_READ : BLC_I_REG;
              if (shift_q[7:1] != DEV_ADDR) begin
                ist_q      <= BLC_I_IDLE;
                sda_oe_out <= 1'b0;
              end
            end else if (ist_q == BLC_I_REG) begin
              ptr_q <= shift_q;
              nxt_q <= BLC_I_DATA;
            end else begin
              wr_q  <= 1'b1;
              wa_q  <= ptr_q;
              wd_q  <= shift_q;
              ptr_q <= ptr_q + 8'h01;
              nxt_q <= BLC_I_DATA;
            end
          end
        end
        BLC_I_ACK: begin
          if (scl_fall) begin
            ist_q      <= nxt_q;
            bit_q      <= 4'h0;
            sda_oe_out <= 1'b0;
            if (nxt_q == BLC_I_READ) begin
              shift_q    <= rd_byte;
              ptr_q      <= ptr_q + 8'h01;
              sda_oe_out <= ~rd_byte[7];
            end
          end
        end
        BLC_I_READ: begin
          if (scl_fall) begin
            if (bit_q == I2C_BITS - 4'h1) begin
              ist_q      <= BLC_I_RACK;
              sda_oe_out <= 1'b0;
            end else begin
              shift_q    <= {shift_q[6:0], 1'b0};
              bit_q      <= bit_q + 4'h1;
              sda_oe_out <= ~shift_q[6];
            end
          end
        end
        BLC_I_RACK: begin
          if (scl_rise) begin
            nack_q <= sda_s2_q;
          end else if (scl_fall) begin
            bit_q <= 4'h0;
            if (nack_q) begin
              ist_q <= BLC_I_IDLE;
            end else begin
              ist_q      <= BLC_I_READ;
              shift_q    <= rd_byte;
              ptr_q      <= ptr_q + 8'h01;
              sda_oe_out <= ~rd_byte[7];
            end
          end
        end
        default: ist_q <= BLC_I_IDLE;
      endcase
    end
  end

  // Open-drain data pin only ever pulls low.
  always_ff @(posedge clk_in) begin
    sda_out <= 1'b0;
  end

  // Register file; only reset or the enable pin clears it, standby leaves it alone.
  always_ff @(posedge clk_in) begin
    if (dev_rst) begin
      en_q      <= RST_ENABLE;
      cfg_q     <= RST_CONFIG;
      pwmc_q    <= RST_PWM;
      code_lo_q <= RST_ZERO[2:0];
      code_hi_q <= RST_ZERO;
    end else if (wr_q) begin
      case (wa_q)
        REG_ENABLE:  en_q      <= wd_q;
        REG_CONFIG:  cfg_q     <= wd_q;
        REG_PWM:     pwmc_q    <= wd_q;
        REG_CODE_LO: code_lo_q <= wd_q[2:0];
        REG_CODE_HI: code_hi_q <= wd_q;
        default:     en_q      <= en_q;
      endcase
    end
  end

  // Hysteresis filters out jitter only when the duty reverses direction.
  assign hyst_thr = CODE_W'(1) << pwmc_q[PWM_HYST_LSB +: 3];
  always_ff @(posedge clk_in) begin
    if (dev_rst) begin
      pwm_code_q <= '0;
      dir_up_q   <= 1'b1;
    end else if (duty_new) begin
      if (duty_raw > pwm_code_q && (dir_up_q || duty_raw - pwm_code_q >= hyst_thr)) begin
        pwm_code_q <= duty_raw;
        dir_up_q   <= 1'b1;
      end else if (duty_raw < pwm_code_q &&
                   (!dir_up_q || pwm_code_q - duty_raw >= hyst_thr)) begin
        pwm_code_q <= duty_raw;
        dir_up_q   <= 1'b0;
      end
    end
  end

  // A held-high input counts as alive; only a quiet low input times out.
  always_ff @(posedge clk_in) begin
    if (dev_rst) begin
      tmo_q   <= '0;
      alive_q <= 1'b0;
    end else if (duty_new || pwm_s2_q) begin
      tmo_q   <= '0;
      alive_q <= 1'b1;
    end else if (tmo_q >= tmo_lim(pwmc_q[PWM_RATE_LSB +: 2])) begin
      alive_q <= 1'b0;
    end else begin
      tmo_q <= tmo_q + TMO_W'(1);
    end
  end

  // Source selection by brightness mode.
  assign i2c_code = {code_hi_q, code_lo_q};
  assign pwm_eff  = (cfg_q[CFG_PWM_BIT] && alive_q) ? pwm_code_q : '0;
  assign product  = pwm_eff * i2c_code;
  always_comb begin
    case (cfg_q[CFG_MODE_LSB +: 2])
      MODE_I2C: sel = i2c_code;
      MODE_PWM: sel = pwm_eff;
      default:  sel = product[2*CODE_W-1:CODE_W];
    endcase
  end

  // Operating state; boost runs only when active.
  always_ff @(posedge clk_in) begin
    if (dev_rst) begin
      target_q <= '0;
      state_q  <= BLC_OFF;
    end else begin
      target_q <= sel;
      if (!en_q[EN_CHIP_BIT]) begin
        state_q <= BLC_OFF;
      end else if (en_q[EN_STR_LSB +: 3] == 3'h0 || sel == '0) begin
        state_q <= BLC_STBY;
      end else begin
        state_q <= BLC_ACTIVE;
      end
    end
  end

  // Ramp one code per step; the exponential target tracks each step.
  always_ff @(posedge clk_in) begin
    if (dev_rst || state_q != BLC_ACTIVE) begin
      rcnt_q <= 8'h00;
      code_q <= '0;
      exp_q  <= '0;
    end else if (rcnt_q != 8'(RAMP_CYC - 1)) begin
      rcnt_q <= rcnt_q + 8'h01;
    end else begin
      rcnt_q <= 8'h00;
      if (target_q > code_q) begin
        code_q <= code_q + CODE_W'(1);
        exp_q  <= (code_q == '0) ? EXP_BASE_NA :
                  exp_q + CUR_W'((41'(exp_q) * 41'(EXP_UP_Q24)) >> EXP_FRAC);
      end else if (target_q < code_q) begin
        code_q <= code_q - CODE_W'(1);
        exp_q  <= (code_q == CODE_W'(1)) ? '0 :
                  exp_q - CUR_W'((41'(exp_q) * 41'(EXP_DN_Q24)) >> EXP_FRAC);
      end
    end
  end

  // Output registers; rounding drift in the tracked exponential stays small.
  always_ff @(posedge clk_in) begin
    if (dev_rst) begin
      led_current_na_out      <= '0;
      led_brightness_code_out <= '0;
      string_en_out           <= 3'h0;
      boost_en_out            <= 1'b0;
      dev_state_out           <= BLC_OFF;
    end else begin
      if (code_q == '0) begin
        led_current_na_out <= '0;
      end else if (cfg_q[CFG_MAP_BIT]) begin
        led_current_na_out <= exp_q;
      end else begin
        led_current_na_out <= LIN_OFFSET_NA + CUR_W'(LIN_STEP_NA * CUR_W'(code_q));
      end
      led_brightness_code_out <= code_q;
      string_en_out           <= (state_q == BLC_ACTIVE) ? en_q[EN_STR_LSB +: 3] : 3'h0;
      boost_en_out            <= (state_q == BLC_ACTIVE);
      dev_state_out           <= state_q;
    end
  end
endmodule

/* File: logic/blc_pwm_sampler.sv */
// Sampling-clock side: glitch filter, duty measurement and duty-to-code division.
`timescale 1ns/10ps
module blc_pwm_sampler
  import blc_pkg::*;
(
  input  wire logic              sample_clk_in,
  input  wire logic              rst_req_in,
  input  wire logic              pwm_in,
  input  wire logic [1:0]        rate_in,
  input  wire logic [1:0]        filt_in,
  output logic      [CODE_W-1:0] duty_code_out,
  output logic                   duty_toggle_out
);
  logic              rst_s1_q, rst_s2_q, pwm_s1_q, pwm_s2_q;
  logic [3:0]        cfg_s1_q, cfg_s2_q;
  logic [4:0]        div_q;
  logic              tick, rise, lvl_q, lvl_prev_q, armed_q, full_q, qbit;
  logic [1:0]        gl_q;
  logic [CNT_W-1:0]  hi_q, per_q, per_l_q;
  logic [CNT_W:0]    rem_q, rem2;
  logic [3:0]        dcnt_q;
  logic [CODE_W-2:0] quo_q;

  function automatic logic [4:0] rate_div(input logic [1:0] r);
    case (r)
      2'b00:   rate_div = DIV_SLOW;
      2'b01:   rate_div = DIV_MID;
      2'b10:   rate_div = DIV_FAST;
      default: rate_div = DIV_MAX;
    endcase
  endfunction

  function automatic logic [1:0] glitch_thr(input logic [1:0] f);
    case (f)
      2'b00:   glitch_thr = 2'h0;
      2'b01:   glitch_thr = 2'(GL_A_CYC);
      2'b10:   glitch_thr = 2'(GL_B_CYC);
      default: glitch_thr = 2'(GL_C_CYC);
    endcase
  endfunction

  // Reset, pin and settings cross in through two flops; settings are quasi-static.
  always_ff @(posedge sample_clk_in) begin
    rst_s1_q <= rst_req_in;
    rst_s2_q <= rst_s1_q;
    pwm_s1_q <= pwm_in;
    pwm_s2_q <= pwm_s1_q;
    cfg_s1_q <= {rate_in, filt_in};
    cfg_s2_q <= cfg_s1_q;
  end

  // Sample-rate divider; a slower rate saves power but loses resolution.
  assign tick = (div_q == 5'h00);
  always_ff @(posedge sample_clk_in) begin
    if (rst_s2_q || tick) begin
      div_q <= rate_div(cfg_s2_q[3:2]) - 5'h01;
    end else begin
      div_q <= div_q - 5'h01;
    end
  end

  // A level change must hold longer than the filter width to be taken.
  always_ff @(posedge sample_clk_in) begin
    if (rst_s2_q) begin
      lvl_q <= 1'b0;
      gl_q  <= 2'h0;
    end else if (pwm_s2_q == lvl_q) begin
      gl_q <= 2'h0;
    end else if (gl_q >= glitch_thr(cfg_s2_q[1:0])) begin
      lvl_q <= pwm_s2_q;
      gl_q  <= 2'h0;
    end else begin
      gl_q <= gl_q + 2'h1;
    end
  end

  // High and period sample counts, restarted at each rising edge.
  assign rise = tick && lvl_q && !lvl_prev_q;
  always_ff @(posedge sample_clk_in) begin
    if (rst_s2_q) begin
      lvl_prev_q <= 1'b0;
      armed_q    <= 1'b0;
      hi_q       <= '0;
      per_q      <= '0;
    end else if (tick) begin
      lvl_prev_q <= lvl_q;
      if (rise) begin
        armed_q <= 1'b1;
        hi_q    <= CNT_W'(1);
        per_q   <= CNT_W'(1);
      end else if (&per_q) begin
        armed_q <= 1'b0;
        hi_q    <= '0;
        per_q   <= '0;
      end else begin
        per_q <= per_q + CNT_W'(1);
        hi_q  <= hi_q + CNT_W'(lvl_q);
      end
    end
  end

  // Restoring division gives high / period as an 11-bit fraction.
  assign rem2 = {rem_q[CNT_W-1:0], 1'b0};
  assign qbit = (rem2 >= {1'b0, per_l_q});
  always_ff @(posedge sample_clk_in) begin
    if (rst_s2_q) begin
      dcnt_q          <= 4'h0;
      rem_q           <= '0;
      per_l_q         <= '0;
      quo_q           <= '0;
      full_q          <= 1'b0;
      duty_code_out   <= '0;
      duty_toggle_out <= 1'b0;
    end else if (rise && armed_q) begin
      rem_q   <= {1'b0, hi_q};
      per_l_q <= per_q;
      full_q  <= (hi_q >= per_q);
      quo_q   <= '0;
      dcnt_q  <= DIV_STEPS;
    end else if (tick && (&per_q)) begin
      // A stuck input reads as full or zero duty.
      duty_code_out   <= lvl_q ? CODE_MAX : '0;
      duty_toggle_out <= ~duty_toggle_out;
    end else if (dcnt_q != 4'h0) begin
      rem_q  <= qbit ? rem2 - {1'b0, per_l_q} : rem2;
      quo_q  <= {quo_q[CODE_W-3:0], qbit};
      dcnt_q <= dcnt_q - 4'h1;
      if (dcnt_q == 4'h1) begin
        duty_code_out   <= full_q ? CODE_MAX : {quo_q, qbit};
        duty_toggle_out <= ~duty_toggle_out;
      end
    end
  end
endmodule

/* File: pkg/blc_pkg.sv */
// Shared constants and types of the backlight brightness control block.
package blc_pkg;
  // Clock rates of the register side and of the sampling side.
  localparam int unsigned CLK_MHZ        = 20;
  localparam int unsigned LINK_PERIOD_NS = 80;

  // Register byte addresses on the serial bus.
  localparam logic [7:0] REG_ENABLE  = 8'h10;
  localparam logic [7:0] REG_CONFIG  = 8'h11;
  localparam logic [7:0] REG_PWM     = 8'h12;
  localparam logic [7:0] REG_CODE_LO = 8'h18;
  localparam logic [7:0] REG_CODE_HI = 8'h19;

  // Reset values: chip on, three strings, sampled input on, linear map.
  localparam logic [7:0] RST_ENABLE = 8'h0F;
  localparam logic [7:0] RST_CONFIG = 8'h21;
  localparam logic [7:0] RST_PWM    = 8'h00;
  localparam logic [7:0] RST_ZERO   = 8'h00;

  // Field positions.
  localparam int unsigned EN_CHIP_BIT  = 0;
  localparam int unsigned EN_STR_LSB   = 1;
  localparam int unsigned CFG_PWM_BIT  = 0;
  localparam int unsigned CFG_MODE_LSB = 5;
  localparam int unsigned CFG_MAP_BIT  = 7;
  localparam int unsigned PWM_FILT_LSB = 0;
  localparam int unsigned PWM_HYST_LSB = 2;
  localparam int unsigned PWM_RATE_LSB = 6;

  // Brightness code and sources.
  localparam int unsigned        CODE_W   = 11;
  localparam logic [CODE_W-1:0]  CODE_MAX = 11'h7FF;
  localparam logic [1:0]         MODE_I2C = 2'b00;
  localparam logic [1:0]         MODE_PWM = 2'b01;

  // Current targets in nanoamps; exponential steps are Q24 factors.
  localparam int unsigned CUR_W         = 25;
  localparam logic [24:0] LIN_OFFSET_NA = 25'h93AE;
  localparam logic [24:0] LIN_STEP_NA   = 25'h2FA3;
  localparam logic [24:0] EXP_BASE_NA   = 25'hC3E8;
  localparam logic [15:0] EXP_UP_Q24    = 16'hC744;
  localparam logic [15:0] EXP_DN_Q24    = 16'hC6A9;
  localparam int unsigned EXP_FRAC      = 24;

  // Sampled-input timeouts per sample rate.
  localparam int unsigned TMO_SLOW_US = 25000;
  localparam int unsigned TMO_MID_US  = 3000;
  localparam int unsigned TMO_FAST_US = 600;
  localparam int unsigned TMO_W       = 20;

  // Full-scale ramp time and the resulting cycles per code step.
  localparam int unsigned RAMP_FULL_US = 2000;
  localparam int unsigned RAMP_CYC     = RAMP_FULL_US * CLK_MHZ / 2047;

  // Glitch filter widths, in link cycles, rounded down.
  localparam int unsigned GL_A_NS  = 100;
  localparam int unsigned GL_B_NS  = 150;
  localparam int unsigned GL_C_NS  = 200;
  localparam int unsigned GL_A_CYC = GL_A_NS / LINK_PERIOD_NS;
  localparam int unsigned GL_B_CYC = GL_B_NS / LINK_PERIOD_NS;
  localparam int unsigned GL_C_CYC = GL_C_NS / LINK_PERIOD_NS;

  // Sample-rate dividers of the link clock, slowest first.
  localparam logic [4:0] DIV_SLOW = 5'h10;
  localparam logic [4:0] DIV_MID  = 5'h03;
  localparam logic [4:0] DIV_FAST = 5'h02;
  localparam logic [4:0] DIV_MAX  = 5'h01;

  // Duty measurement counter width, divider length and serial bits per byte.
  localparam int unsigned CNT_W     = 18;
  localparam logic [3:0]  DIV_STEPS = 4'hB;
  localparam logic [3:0]  I2C_BITS  = 4'h8;

  typedef enum logic [1:0] {
    BLC_OFF    = 2'b00,
    BLC_STBY   = 2'b01,
    BLC_ACTIVE = 2'b10
  } blc_state_t;

  typedef enum logic [2:0] {
    BLC_I_IDLE = 3'b000,
    BLC_I_ADDR = 3'b001,
    BLC_I_REG  = 3'b010,
    BLC_I_DATA = 3'b011,
    BLC_I_ACK  = 3'b100,
    BLC_I_READ = 3'b101,
    BLC_I_RACK = 3'b110
  } blc_i2c_t;
endpackage

/* File: test/blc_backlight_ctrl_chk.sv */
// Port assertions of the backlight brightness control.
`timescale 1ns/10ps
module blc_backlight_ctrl_chk
  import blc_pkg::*;
(
  input wire logic              clk_in,
  input wire logic              rst_in,
  input wire logic              master_enable_pin_in,
  input wire logic              sda_oe_out,
  input wire logic [CUR_W-1:0]  led_current_na_out,
  input wire logic [CODE_W-1:0] led_brightness_code_out,
  input wire logic [2:0]        string_en_out,
  input wire logic              boost_en_out,
  input wire logic [1:0]        dev_state_out
);
  // One domain; outputs lag the state by a cycle, hence the past terms.
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  wire act = (dev_state_out == BLC_ACTIVE);
  AST_SHDN_STATE: assert property ((!master_enable_pin_in) [*6] |-> !dev_state_out)
    else $error("state not off with enable pin low");
  AST_SHDN_BUS: assert property ((!master_enable_pin_in) [*6] |-> !sda_oe_out)
    else $error("bus answered with enable pin low");
  AST_STR_ACT: assert property (string_en_out != 3'b000 |-> act || $past(act))
    else $error("strings on outside active");
  AST_BOOST_ACT: assert property (boost_en_out |-> act || $past(act))
    else $error("boost on outside active");
  AST_IDLE_DARK: assert property ((!act) [*3] |-> !led_current_na_out)
    else $error("current while not active");
  AST_ZERO_CODE: assert property ((led_brightness_code_out == '0) [*3] |-> !led_current_na_out)
    else $error("current with code zero");
  AST_RAMP_STEP: assert property (act && $past(act) && $past(act, 2) |->
    led_brightness_code_out - $past(led_brightness_code_out) inside {11'h000, 11'h001, 11'h7FF})
    else $error("code moved more than one step");
  AST_RAMP_START: assert property ($rose(act) |-> (led_brightness_code_out <= 11'h001) [*2])
    else $error("code did not start low");
  COV_ACT: cover property ($rose(act));
  COV_STBY: cover property (dev_state_out == BLC_STBY);
  COV_ACK: cover property ($rose(sda_oe_out));
endmodule

bind blc_backlight_ctrl blc_backlight_ctrl_chk blc_backlight_ctrl_chk_inst (
  .clk_in(clk_in), .rst_in(rst_in), .master_enable_pin_in(master_enable_pin_in),
  .sda_oe_out(sda_oe_out), .led_current_na_out(led_current_na_out),
  .led_brightness_code_out(led_brightness_code_out), .string_en_out(string_en_out),
  .boost_en_out(boost_en_out), .dev_state_out(dev_state_out)
);

/* File: test/blc_backlight_ctrl_tb.sv */
// Self-checking bench: registers, sources, mapping and shutdown.
`timescale 1ns/10ps
module blc_backlight_ctrl_tb;
  import blc_pkg::*;
  logic              clk_in = 1'b0;
  logic              rst_in = 1'b1;
  logic              smp = 1'b0;
  logic              en = 1'b0;
  logic              scl, sda_low, pwm, oe, boost;
  logic [CUR_W-1:0]  cur;
  logic [CODE_W-1:0] code;
  logic [2:0]        str;
  logic [1:0]        st;
  int                fail_count = 0;
  int                checks = 0;
  int                cyc = 0;
  // Pulled-up data wire, low whenever either side pulls it.
  wire               sda = !(sda_low || oe);
  always #25 clk_in = !clk_in;
  initial begin
    #13;
    forever #40 smp = !smp;
  end
  blc_backlight_ctrl #(.TMO_SLOW_CYC(4000), .TMO_MID_CYC(2000), .TMO_FAST_CYC(1000))
  blc_backlight_ctrl_inst (.clk_in(clk_in), .rst_in(rst_in), .sample_clk_in(smp),
    .master_enable_pin_in(en), .scl_in(scl), .sda_in(sda), .pwm_in(pwm), .sda_out(),
    .sda_oe_out(oe), .led_current_na_out(cur), .led_brightness_code_out(code),
    .string_en_out(str), .boost_en_out(boost), .dev_state_out(st));
  blc_host_model blc_host_model_inst (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
    .sda_low_out(sda_low), .pwm_out(pwm));
  // Hang guard, about a quarter above the expected run length.
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      fail_count = fail_count + 1;
      conclude();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic reg_io(input logic rd, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic ok;
    blc_host_model_inst.rw(rd, a, d, q, ok);
    check(ok, 1);
    if (rd) check(q, d);
  endtask
  task automatic gap();
    repeat (10) @(negedge clk_in);
  endtask
  // Waits until the ramp has rested for longer than one step period.
  task automatic settle();
    int n = 0;
    int s = 0;
    logic [CODE_W-1:0] p;
    p = code;
    while (s < 25 && n < 30000) begin
      @(negedge clk_in);
      s = (code === p && st === BLC_ACTIVE) ? s + 1 : 0;
      p = code;
      n++;
    end
  endtask
  task automatic t_defaults();
    reg_io(1, REG_ENABLE, RST_ENABLE);
    reg_io(1, REG_CONFIG, RST_CONFIG);
    reg_io(1, REG_CODE_HI, RST_ZERO);
    reg_io(1, 8'h20, 8'h00);
    check(st, BLC_STBY);
    $display("done defaults");
  endtask
  task automatic t_pwm();
    blc_host_model_inst.hi_t = 16;
    settle();
    check(st, BLC_ACTIVE);
    check(32'(code >= 11'd480 && code <= 11'd544), 1);
    check(cur, LIN_OFFSET_NA + LIN_STEP_NA * code);
    check({boost, str}, 4'hF);
    $display("done duty source");
  endtask
  task automatic t_serial();
    real e;
    e = 50000.0 * $pow(1.003040572, 1029.0);
    reg_io(0, REG_CONFIG, 8'h81);
    gap();
    check(st, BLC_STBY);
    reg_io(0, REG_CODE_LO, 8'h05);
    reg_io(0, REG_CODE_HI, 8'h80);
    settle();
    check(code, 11'h405);
    check(32'(cur > e * 0.99 && cur < e * 1.01), 1);
    reg_io(0, REG_CONFIG, 8'h01);
    gap();
    check(cur, LIN_OFFSET_NA + LIN_STEP_NA * 11'h405);
    reg_io(0, REG_CONFIG, 8'h41);
    settle();
    check(code, 11'd257);
    $display("done serial code");
  endtask
  task automatic t_strings();
    reg_io(0, REG_ENABLE, 8'h01);
    gap();
    check({st, str}, {BLC_STBY, 3'b000});
    reg_io(0, REG_ENABLE, 8'h0B);
    gap();
    check({st, str}, {BLC_ACTIVE, 3'b101});
    reg_io(0, REG_ENABLE, 8'h0A);
    gap();
    check({st, boost}, {BLC_OFF, 1'b0});
    reg_io(1, REG_CONFIG, 8'h41);
    $display("done strings");
  endtask
  task automatic t_shutdown();
    logic [7:0] q;
    logic ok;
    en = 1'b0;
    gap();
    check(st, BLC_OFF);
    blc_host_model_inst.rw(0, REG_CONFIG, 8'h55, q, ok);
    check(ok, 0);
    en = 1'b1;
    gap();
    reg_io(1, REG_CONFIG, RST_CONFIG);
    reg_io(0, REG_PWM, 8'hC0);
    reg_io(1, REG_PWM, 8'hC0);
    $display("done shutdown");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    en = 1'b1;
    repeat (40) @(negedge clk_in);
    t_defaults();
    t_pwm();
    t_serial();
    t_strings();
    t_shutdown();
    conclude();
  end
endmodule

/* File: test/blc_host_model.sv */
// Host partner: serial-bus master and duty-cycle brightness source.
`timescale 1ns/10ps
module blc_host_model #(
  parameter logic [6:0] ADDR = 7'h40
) (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out,
  output logic      pwm_out
);
  int hi_t = 0;
  // Edges fall on whole 1280 ns sample ticks, so the duty count is exact.
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
    forever begin
      pwm_out = (hi_t > 0);
      #(1280 * hi_t);
      pwm_out = 1'b0;
      #(1280 * (64 - hi_t));
    end
  end
  // Bus lines move only on falling clock edges, slow enough for the pin sync.
  task automatic hp(input logic c, input logic d);
    repeat (20) @(negedge clk_in);
    scl_out = c;
    sda_low_out = !d;
  endtask
  task automatic start();
    hp(1, 1);
    hp(1, 0);
    hp(0, 0);
  endtask
  // Data changes only while the clock is low; ones release the wire for reading.
  task automatic xfer(input logic [7:0] tx, input logic ak_tx, output logic [7:0] rx,
                      output logic ak_rx);
    for (int i = 7; i >= 0; i--) begin
      hp(0, tx[i]);
      hp(1, tx[i]);
      rx[i] = sda_in;
      hp(0, tx[i]);
    end
    hp(0, ak_tx);
    hp(1, ak_tx);
    ak_rx = !sda_in;
    hp(0, ak_tx);
  endtask
  task automatic rw(input logic rd, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] q, output logic ok);
    logic k1, k2, k3;
    start();
    xfer({ADDR, 1'b0}, 1'b1, q, k1);
    xfer(a, 1'b1, q, k2);
    if (rd) begin
      start();
      xfer({ADDR, 1'b1}, 1'b1, q, k3);
    end
    xfer(rd ? 8'hFF : d, 1'b1, q, k3);
    hp(0, 0);
    hp(1, 0);
    hp(1, 1);
    ok = k1 & k2 & (rd | k3);
  endtask
endmodule
